// file: hdl/branch_condition.sv
// combinational flag test for one branch opcode
// assumes flags are stable while the opcode is presented
`timescale 1ns/1ps
`include "branch_defines.svh"
module branch_condition (
  input wire logic [2:0] op,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic negative_flag,
  output logic taken
);
  always_comb begin
    taken = 1'b0;
    unique case (branch_pkg::branch_op_e'(op))
      branch_pkg::op_branch_equal: taken = (zero_flag == `FLAG_SET); // see [RL1]
      branch_pkg::op_branch_not_equal: taken = (zero_flag == `FLAG_CLEAR); // see [RL2]
      branch_pkg::op_branch_carry_set: taken = (carry_flag == `FLAG_SET); // see [RL3]
      branch_pkg::op_branch_carry_cleared:
        taken = (carry_flag == `FLAG_CLEAR); // see [RL4]
      // same test as carry cleared, unsigned view
      branch_pkg::op_branch_same_or_higher:
        taken = (carry_flag == `FLAG_CLEAR); // see [RL5]
      branch_pkg::op_branch_lower: taken = (carry_flag == `FLAG_SET); // see [RL6]
      branch_pkg::op_branch_minus:
        taken = (negative_flag == `FLAG_SET); // see [RL7]
      branch_pkg::op_none: taken = 1'b0;
    endcase
  end
endmodule : branch_condition

// file: hdl/branch_target.sv
// relative target adder: pc plus signed offset plus one
// assumes pc wraps modulo its width
`timescale 1ns/1ps
`include "branch_defines.svh"
module branch_target #(
  parameter int PC_W = `PC_WIDTH,
  parameter int OFF_W = `OFFSET_WIDTH
) (
  input wire logic [PC_W-1:0] pc,
  input wire logic [OFF_W-1:0] offset,
  output logic [PC_W-1:0] target
);
  logic [PC_W-1:0] offset_ext;
  // sign extension reaches targets behind the branch too
  assign offset_ext = {{(PC_W-OFF_W){offset[OFF_W-1]}}, offset}; // see [RL12]
  assign target = pc + offset_ext + PC_W'(`PC_STEP); // see [RL8]
endmodule : branch_target

// file: hdl/conditional_branch_unit.sv
// conditional relative branch execution for an 8-bit core
// assumes decode presents one branch per issue pulse, flags from core
// Overview of operation
// [RL1] equal branch taken when zero flag set
// [RL2] not-equal branch taken when zero clear
// [RL3] carry-set branch taken when carry set
// [RL4] carry-cleared branch taken when carry clear
// [RL5] same-or-higher taken when carry clear
// [RL6] lower branch taken when carry set
// [RL7] minus branch taken when negative set
// [RL8] taken: pc gets pc plus offset plus one
// [RL9] status flags never altered by branches
// [RL10] each branch finishes in one or two cycles
// [RL11] fall through one cycle, taken two
// [RL12] offset is two's-complement signed
`timescale 1ns/1ps
`include "branch_defines.svh"
module conditional_branch_unit #(
  parameter int PC_W = `PC_WIDTH,
  parameter int OFF_W = `OFFSET_WIDTH
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic issue,
  input wire logic [2:0] op,
  input wire logic [OFF_W-1:0] offset,
  input wire logic [PC_W-1:0] pc,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic negative_flag,
  output logic busy,
  output logic done,
  output logic taken,
  output logic pc_load,
  output logic [PC_W-1:0] pc_next
);
  branch_pkg::branch_state_e state_r;
  logic cond;
  logic [PC_W-1:0] target;
  logic [PC_W-1:0] target_r;
  logic accept;
  logic reload;

  branch_condition u_cond (
    .op(op),
    .zero_flag(zero_flag),
    .carry_flag(carry_flag),
    .negative_flag(negative_flag),
    .taken(cond)
  );

  branch_target #(.PC_W(PC_W), .OFF_W(OFF_W)) u_target (
    .pc(pc),
    .offset(offset),
    .target(target)
  );

  // new branches ignored while a taken one is reloading
  assign accept = issue && (state_r == branch_pkg::st_idle);
  assign reload = (state_r == branch_pkg::st_reload);

  // flags are inputs only; no flag output exists, see [RL9]
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= branch_pkg::st_idle;
    end else if (clk_en) begin
      unique case (state_r)
        branch_pkg::st_idle: begin
          if (accept && cond) begin
            state_r <= branch_pkg::st_reload; // see [RL11]
          end
        end
        branch_pkg::st_reload: state_r <= branch_pkg::st_idle; // see [RL10]
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      target_r <= PC_W'(`PC_RESET);
    end else if (clk_en && accept && cond) begin
      target_r <= target; // see [RL8]
    end
  end

  // done one cycle after issue when falling through, two when taken
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done <= 1'b0;
    end else if (clk_en) begin
      done <= reload || (accept && !cond); // see [RL10] [RL11]
    end
  end

  // outcome holds until the next branch finishes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      taken <= 1'b0;
    end else if (clk_en) begin
      if (reload) begin
        taken <= 1'b1;
      end else if (accept && !cond) begin
        taken <= 1'b0;
      end
    end
  end

  // load strobe only for a taken branch; fall through just steps
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pc_load <= 1'b0;
    end else if (clk_en) begin
      pc_load <= reload; // see [RL8]
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pc_next <= PC_W'(`PC_RESET);
    end else if (clk_en) begin
      if (reload) begin
        pc_next <= target_r; // see [RL8]
      end else if (accept && !cond) begin
        pc_next <= pc + PC_W'(`PC_STEP); // see [RL11]
      end
    end
  end

  // busy spans the reload cycle, so a second issue is refused there
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (clk_en) begin
      if (reload) begin
        busy <= 1'b0;
      end else if (accept && cond) begin
        busy <= 1'b1; // see [RL11]
      end
    end
  end
endmodule : conditional_branch_unit

// file: pkg/branch_defines.svh
// constants for the conditional branch unit
// assumes inclusion by bare name; definitions only
`ifndef BRANCH_DEFINES_SVH
`define BRANCH_DEFINES_SVH
`define PC_WIDTH 16
`define OFFSET_WIDTH 7
`define PC_RESET 16'h0000
`define PC_STEP 16'h0001
`define FLAG_SET 1'b1
`define FLAG_CLEAR 1'b0
`define OP_WIDTH 3
`endif

// file: pkg/branch_pkg.sv
// types for the conditional branch unit
// assumes branch_defines.svh is on the include path
`include "branch_defines.svh"
package branch_pkg;
  typedef enum logic [2:0] {
    op_branch_equal = 3'h0,
    op_branch_not_equal = 3'h1,
    op_branch_carry_set = 3'h2,
    op_branch_carry_cleared = 3'h3,
    op_branch_same_or_higher = 3'h4,
    op_branch_lower = 3'h5,
    op_branch_minus = 3'h6,
    op_none = 3'h7
  } branch_op_e;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_reload = 2'h1
  } branch_state_e;
endpackage : branch_pkg

// file: testbench/branch_properties.sv
// assertions on branch unit ports
// assumes a stall or reset cancels any check it spans
`timescale 1ns/1ps
module branch_properties (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic issue,
  input wire logic [2:0] op,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic negative_flag,
  input wire logic busy,
  input wire logic done,
  input wire logic taken,
  input wire logic pc_load
);
  default clocking @(posedge core_clk); endclocking
  // frozen cycles break every cycle count, so they disable the check
  default disable iff (reset || !clk_en);
  wire go = issue && !busy;
  // carry tests pair up: 2,5 on set, 3,4 on clear
  wire t = op < 3'h2 ? op[0] ^ zero_flag : op == 3'h6 ? negative_flag
    : op != 3'h7 && (op == 3'h2 || op == 3'h5) ^ !carry_flag;
  fall_through_a: assert property (
    go && !t |=> done && !taken) else $error("fall through");
  taken_timing_a: assert property (
    go && t |=> busy ##1 done && taken) else $error("taken timing");
  load_done_a: assert property (
    pc_load |-> done && taken) else $error("load without done");
  reload_busy_a: assert property (
    busy |=> !busy && done) else $error("busy too long");
  quiet_done_a: assert property (
    !issue && !busy |=> !done) else $error("stray done");
  equal_test_a: assert property (
    go && op == 3'h0 |=> busy == $past(zero_flag)) else $error("equal");
  lower_test_a: assert property (
    go && op == 3'h5 |=> busy == $past(carry_flag)) else $error("lower");
  minus_test_a: assert property (
    go && op == 3'h6 |=> busy == $past(negative_flag)) else $error("minus");
endmodule : branch_properties

// file: testbench/core_model.sv
// core pc register beside the unit
// assumes pc_next valid with done
`timescale 1ns/1ps
module core_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic done,
  input wire logic [15:0] pc_next,
  output logic [15:0] pc_r
);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) pc_r <= 16'h0000;
    else if (done) pc_r <= pc_next;
  end
endmodule : core_model

// file: testbench/testbench.sv
// branch bench: every op and flag mix, wrapping targets
// assumes design and checker compiled first
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, reset = 1, issue = 0, busy, done, taken, pc_load;
  logic clk_en = 1;
  logic zero_flag = 0, carry_flag = 0, negative_flag = 0;
  logic [2:0] op = 3'h7;
  logic [6:0] offset = 7'h00;
  logic [15:0] pc, pc_next;
  int n_errors = 0, compares = 0;
  always #4 core_clk = ~core_clk;
  conditional_branch_unit dut (.core_clk, .reset, .clk_en, .issue,
    .op, .offset, .pc, .zero_flag, .carry_flag, .negative_flag, .busy,
    .done, .taken, .pc_load, .pc_next);
  core_model core (.core_clk, .reset, .done, .pc_next, .pc_r(pc));
  task chk(input string s, input logic [15:0] a, input logic [15:0] b);
    compares++;
    if (a !== b) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", s, b, a);
    end
  endtask : chk
  task final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic run(input logic [2:0] o, f, input logic [6:0] k,
    input logic t);
    logic [15:0] e;
    int w;
    e = pc + 16'h1 + (t ? {{9{k[6]}}, k} : 16'h0);
    {negative_flag, carry_flag, zero_flag} = f;
    op = o;
    offset = k;
    issue = 1;
    w = 0;
    @(negedge core_clk) issue = 0;
    // bounded wait: a lost done must not hang
    while (!done && w < 9) begin
      @(negedge core_clk);
      w++;
    end
    chk("cycles", w[15:0], 16'(t));
    if (w == 9) final_report;
    chk("taken", 16'(taken),
      16'(t));
    chk("load", 16'(pc_load), 16'(t));
    @(negedge core_clk) chk("pc", pc, e);
  endtask : run
  // taken branch frozen mid-reload, then an issue while busy is refused
  task t_stall;
    logic [15:0] e;
    e = pc + 16'h11;
    carry_flag = 0;
    op = 3'h3;
    offset = 7'h10;
    issue = 1;
    @(negedge core_clk);
    issue = 0;
    clk_en = 0;
    repeat (2) @(negedge core_clk);
    chk("stall busy", 16'(busy), 16'h1);
    chk("stall done", 16'(done), 16'h0);
    clk_en = 1;
    op = 3'h7;
    issue = 1;
    @(negedge core_clk);
    issue = 0;
    chk("reload done", 16'(done), 16'h1);
    chk("reload load", 16'(pc_load), 16'h1);
    @(negedge core_clk);
    chk("refused", 16'(done), 16'h0);
    chk("stall pc", pc, e);
  endtask : t_stall
  // reset while busy, then a branch on the first edge after release
  task t_reset;
    negative_flag = 1;
    op = 3'h6;
    offset = 7'h01;
    issue = 1;
    @(negedge core_clk);
    issue = 0;
    reset = 1;
    @(negedge core_clk);
    chk("reset busy", 16'(busy), 16'h0);
    chk("reset done", 16'(done), 16'h0);
    chk("reset taken", 16'(taken), 16'h0);
    chk("reset next", pc_next, 16'h0000);
    reset = 0;
    run(3'h0, 3'h0, 7'h05, 1'b0);
  endtask : t_reset
  task t_wrap;
    run(3'h6, 3'h4, 7'h40, 1'b1);
    run(3'h1, 3'h0, 7'h3f, 1'b1);
  endtask : t_wrap
  task t_flags;
    logic [2:0] o, f;
    for (int i = 0; i < 64; i++) begin
      o = i[5:3];
      f = i[2:0];
      run(o, f, 7'h05, o < 3'h2 ? o[0] ^ f[0] : o == 3'h6 ? f[2]
        : o != 3'h7 && (o == 3'h2 || o == 3'h5) ^ !f[1]);
    end
  endtask : t_flags
  initial begin
    repeat (3) @(negedge core_clk);
    reset = 0;
    t_wrap;
    t_flags;
    t_stall;
    t_reset;
    final_report;
  end
endmodule : testbench
bind conditional_branch_unit branch_properties props (.core_clk, .reset,
  .clk_en, .issue, .op, .zero_flag, .carry_flag, .negative_flag, .busy, .done,
  .taken, .pc_load);
